// ==== design/perf_monitor_regs.svh ====
// register offsets, field positions and reset values of the performance monitor
`ifndef PERF_MONITOR_REGS_SVH
`define PERF_MONITOR_REGS_SVH
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_STATUS 8'h08
`define OFS_SAMPLE_INSTR 8'h10
`define OFS_SAMPLE_DATA 8'h14
`define CNT_REGION 3'h1
`define CTRL_A_MODE_LSB 0
`define CTRL_A_MODE_W 4
`define CTRL_A_TRIG_LSB 4
`define CTRL_A_TBSEL_LSB 6
`define CTRL_A_FREEZE_BIT 8
`define CTRL_A_HIST_BIT 9
`define CTRL_A_LINK_BIT 10
`define CTRL_A_TRACE_BIT 11
`define CTRL_A_EXC_EN_BIT 12
`define CTRL_A_THR_LSB 16
`define CTRL_A_RESET 32'h0000_0000
`define CTRL_B_RESET 32'h0000_0000
`define ST_EXC_BIT 0
`define ST_TRIG_BIT 1
`define ST_COUNT_BIT 2
`define ST_COUPLED_BIT 3
`define ST_TRACE_LSB 4
`define EVT_SEL_W 4
`define SAMPLE_PERIOD_LAST 4'hF
`define THR_W 6
`endif

// ==== design/perf_monitor_pkg.sv ====
// types shared by the performance monitor files
`default_nettype none
package perf_monitor_pkg;
	typedef enum logic [3:0] {
		MODE_OFF, MODE_ON, MODE_PRIV, MODE_PROB, MODE_MARK_PROB, MODE_UNMARK_PROB,
		MODE_MARK_PRIV, MODE_UNMARK_PRIV, MODE_MARK, MODE_UNMARK
	} mode_t;
	typedef enum logic [1:0] {TRIG_WRITE, TRIG_BREAKPOINT, TRIG_TIMEBASE, TRIG_NEGATIVE} trig_t;
endpackage
`default_nettype wire

// ==== design/event_counter_cell.sv ====
// one event counter: load, add or history shift
`default_nettype none
`include "perf_monitor_regs.svh"
module event_counter_cell #(
	parameter int CNT_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [CNT_W-1:0] load_val,
	input wire logic count_en,
	input wire logic history,
	input wire logic event_bit,
	input wire logic shift_in,
	output logic [CNT_W-1:0] value_reg
);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			value_reg <= '0;
		else if (load)
			value_reg <= load_val;
		else if (count_en && history)
			value_reg <= {value_reg[CNT_W-2:0], shift_in}; // see [R18] [R19]
		else if (count_en)
			value_reg <= value_reg + CNT_W'(event_bit); // see [R23]
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_hist_shift;
		count_en && history && !load |=> value_reg == {$past(value_reg[CNT_W-2:0]), $past(shift_in)};
	endproperty
	a_hist_shift: assert property (p_hist_shift) else $error("history shift wrong"); // see [R19]
	property p_idle_hold;
		!count_en && !load |=> $stable(value_reg);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("counter moved while idle"); // see [R26]
endmodule
`default_nettype wire

// ==== design/sample_unit.sv ====
// instruction sampling, sample address registers, coupling flag and thresholder
`default_nettype none
`include "perf_monitor_regs.svh"
module sample_unit #(
	parameter int ADDR_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic freeze,
	input wire logic trace_mode,
	input wire logic [`THR_W-1:0] threshold,
	input wire logic dispatch_valid,
	input wire logic [ADDR_W-1:0] dispatch_addr,
	input wire logic lsu_valid,
	input wire logic lsu_sampled,
	input wire logic lsu_store,
	input wire logic lsu_cacheable,
	input wire logic [ADDR_W-1:0] lsu_ea,
	input wire logic access_done,
	output logic sample_tag,
	output logic [ADDR_W-1:0] sample_instr_addr,
	output logic [ADDR_W-1:0] sample_data_addr,
	output logic coupled_reg,
	output logic thr_exceed_reg
);
	logic [3:0] disp_cnt_reg;
	logic thr_busy_reg;
	logic [`THR_W:0] lat_reg;
	logic sia_wr;
	logic sda_wr;
	logic thr_start;

	// one tag per sixteen dispatches keeps at most one sampled op in flight
	assign sample_tag = dispatch_valid && disp_cnt_reg == `SAMPLE_PERIOD_LAST; // see [R11]
	assign sia_wr = sample_tag && !freeze; // see [R13]
	assign sda_wr = lsu_valid && (trace_mode || (lsu_sampled && !freeze)); // see [R12] [R22]
	// uncached stores have no visible completion, so they are not timed
	assign thr_start = lsu_valid && lsu_sampled && (!lsu_store || lsu_cacheable); // see [R17]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			disp_cnt_reg <= '0;
		else if (dispatch_valid)
			disp_cnt_reg <= disp_cnt_reg + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sample_instr_addr <= '0;
			sample_data_addr <= '0;
		end
		else
		begin
			if (sia_wr)
				sample_instr_addr <= dispatch_addr; // see [R12]
			if (sda_wr)
				sample_data_addr <= lsu_ea;
		end
	end

	// set wins: a data write in the same cycle leaves the pair coupled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			coupled_reg <= 1'b0;
		else if (sda_wr)
			coupled_reg <= 1'b1; // see [R14]
		else if (sia_wr)
			coupled_reg <= 1'b0; // see [R14]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			thr_busy_reg <= 1'b0;
			lat_reg <= '0;
			thr_exceed_reg <= 1'b0;
		end
		else
		begin
			// access_done marks load data return or store written into L1
			thr_exceed_reg <= thr_busy_reg && access_done
				&& lat_reg > {1'b0, threshold}; // see [R15] [R16] [R24]
			if (thr_start)
			begin
				thr_busy_reg <= 1'b1;
				lat_reg <= '0;
			end
			else if (access_done)
				thr_busy_reg <= 1'b0;
			else if (thr_busy_reg && !lat_reg[`THR_W])
				lat_reg <= lat_reg + 7'h01;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_tag_period;
		dispatch_valid && disp_cnt_reg == 4'hF |-> sample_tag ##1 disp_cnt_reg == 4'h0;
	endproperty
	a_tag_period: assert property (p_tag_period) else $error("sample tag missed"); // see [R11]
	property p_coupled_set;
		sda_wr |=> coupled_reg && sample_data_addr == $past(lsu_ea);
	endproperty
	a_coupled_set: assert property (p_coupled_set) else $error("coupling flag not set"); // see [R14]
	property p_freeze_hold;
		freeze && !trace_mode |=> $stable(sample_instr_addr) && $stable(sample_data_addr);
	endproperty
	a_freeze_hold: assert property (p_freeze_hold) else $error("sample regs moved"); // see [R13]
	c_threshold: cover property (thr_exceed_reg);
endmodule
`default_nettype wire

// ==== design/perf_monitor_count_control.sv ====
// performance monitor: count enable, triggers, breakpoint match, history and trace
// Functional notes
// [R01] count only while problem and mark bits match the selected state
// [R02] eight selectable states from privilege and mark combinations
// [R03] two extra modes: always count, never count
// [R04] by default a software write that enables counting starts it
// [R05] counting may first start on instruction breakpoint match
// [R06] counting may start on time base rising bit or counter one negative
// [R07] breakpoint match compares only the instruction address
// [R08] breakpoint match only for branch queue instructions
// [R09] match reported at branch finish, even if later cancelled
// [R10] breakpoint match valid only while the monitor is enabled
// [R11] every sixteenth dispatched instruction is tagged as sampled
// [R12] store sampled instruction and data addresses, count sampled L2 misses
// [R13] exception condition freezes both sample address registers; in trace mode the code still writes sample_data_addr
// [R14] coupling flag set on data address write, cleared on instruction write
// [R15] thresholding counts sampled accesses slower than threshold
// [R16] cacheable store completes when written into first-level cache
// [R17] uncached sampled store does not hold sample addresses; the code still writes sample_data_addr and only keeps it out of thresholding
// [R18] history mode shifts per-cycle status, pairs link for 64 cycles
// [R19] history msb is oldest cycle, lsb newest
// [R20] trace mode issues one instruction after predecessor completes
// [R21] trace mode records load, store, length field access, map change
// [R22] trace mode saves every load and store data address
// [R23] eight 32-bit counters, one selected event each
// [R24] threshold spans 0 to 63 cycles
// [R25] counter negative when msb is one, raising exception condition
// [R26] counters hold their values while counting is disabled
//
// The APB slave port and the register offsets were decided locally.
`default_nettype none
`include "perf_monitor_regs.svh"
module perf_monitor_count_control #(
	parameter int N_CNT = 8,
	parameter int CNT_W = 32,
	parameter int ADDR_W = 32,
	parameter int EVT_W = 14
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic problem_state_bit,
	input wire logic process_mark_bit,
	input wire logic [3:0] time_base_bits,
	input wire logic [EVT_W-1:0] event_in,
	input wire logic l2_miss_sampled,
	input wire logic dispatch_valid,
	input wire logic [ADDR_W-1:0] dispatch_addr,
	input wire logic branch_finish_valid,
	input wire logic [ADDR_W-1:0] branch_finish_addr,
	input wire logic [ADDR_W-1:0] instr_breakpoint_reg,
	input wire logic lsu_valid,
	input wire logic lsu_sampled,
	input wire logic lsu_store,
	input wire logic lsu_cacheable,
	input wire logic [ADDR_W-1:0] lsu_ea,
	input wire logic access_done,
	input wire logic complete_valid,
	input wire logic complete_load,
	input wire logic complete_store,
	input wire logic complete_len_access,
	input wire logic complete_map_change,
	output logic sample_tag,
	output logic issue_allow,
	output logic save_restore_status_coupled,
	output logic [3:0] save_restore_status_trace,
	output logic monitor_exception,
	output logic count_active
);
	// ****************************************
	// control registers and decode
	// ****************************************
	logic [31:0] monitor_control_a;
	logic [31:0] monitor_control_b;
	perf_monitor_pkg::mode_t mode;
	perf_monitor_pkg::trig_t trig_sel;
	logic [1:0] tb_sel;
	logic freeze_on_exc, history, link, trace_mode, exc_en;
	logic [`THR_W-1:0] threshold;
	logic wr_en, rd_setup, cnt_hit, mapped;
	logic [2:0] cnt_idx;

	assign mode = perf_monitor_pkg::mode_t'(monitor_control_a[`CTRL_A_MODE_LSB +: `CTRL_A_MODE_W]);
	assign trig_sel = perf_monitor_pkg::trig_t'(monitor_control_a[`CTRL_A_TRIG_LSB +: 2]);
	assign tb_sel = monitor_control_a[`CTRL_A_TBSEL_LSB +: 2];
	assign freeze_on_exc = monitor_control_a[`CTRL_A_FREEZE_BIT];
	assign history = monitor_control_a[`CTRL_A_HIST_BIT];
	assign link = monitor_control_a[`CTRL_A_LINK_BIT];
	assign trace_mode = monitor_control_a[`CTRL_A_TRACE_BIT];
	assign exc_en = monitor_control_a[`CTRL_A_EXC_EN_BIT];
	assign threshold = monitor_control_a[`CTRL_A_THR_LSB +: `THR_W]; // see [R24]

	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign cnt_idx = paddr[4:2];
	assign cnt_hit = paddr[7:5] == `CNT_REGION && paddr[1:0] == 2'h0;
	assign mapped = cnt_hit || paddr == `OFS_CTRL_A || paddr == `OFS_CTRL_B
		|| paddr == `OFS_STATUS || paddr == `OFS_SAMPLE_INSTR || paddr == `OFS_SAMPLE_DATA;
	// zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			monitor_control_a <= `CTRL_A_RESET;
			monitor_control_b <= `CTRL_B_RESET;
		end
		else if (wr_en && paddr == `OFS_CTRL_A)
			monitor_control_a <= pwdata;
		else if (wr_en && paddr == `OFS_CTRL_B)
			monitor_control_b <= pwdata;
	end

	// ****************************************
	// state match and count enable
	// ****************************************
	logic state_ok, monitor_en, triggered_reg, exception_reg, count_en;
	logic bp_hit, tb_prev_reg, tb_rise, trig_fire, ctrl_write, neg_any, ctrl_a_wr, arm_write;
	logic [N_CNT-1:0] msb_vec;

	always_comb
	begin
		unique case (mode) // see [R01] [R02] [R03]
			perf_monitor_pkg::MODE_OFF: state_ok = 1'b0;
			perf_monitor_pkg::MODE_ON: state_ok = 1'b1;
			perf_monitor_pkg::MODE_PRIV: state_ok = !problem_state_bit;
			perf_monitor_pkg::MODE_PROB: state_ok = problem_state_bit;
			perf_monitor_pkg::MODE_MARK_PROB: state_ok = process_mark_bit && problem_state_bit;
			perf_monitor_pkg::MODE_UNMARK_PROB: state_ok = !process_mark_bit && problem_state_bit;
			perf_monitor_pkg::MODE_MARK_PRIV: state_ok = process_mark_bit && !problem_state_bit;
			perf_monitor_pkg::MODE_UNMARK_PRIV: state_ok = !process_mark_bit && !problem_state_bit;
			perf_monitor_pkg::MODE_MARK: state_ok = process_mark_bit;
			perf_monitor_pkg::MODE_UNMARK: state_ok = !process_mark_bit;
			default: state_ok = 1'b0;
		endcase
	end

	assign monitor_en = state_ok;
	// only branch-queue ops raise branch_finish_valid; the monitor enable is
	// consulted, translation mode deliberately is not
	assign bp_hit = branch_finish_valid && branch_finish_addr == instr_breakpoint_reg
		&& monitor_en; // see [R07] [R08] [R09] [R10]
	assign tb_rise = time_base_bits[tb_sel] && !tb_prev_reg;
	assign ctrl_a_wr = wr_en && paddr == `OFS_CTRL_A;
	// the trigger field being written decides, not the one it replaces
	assign arm_write = ctrl_a_wr && pwdata[`CTRL_A_TRIG_LSB +: 2] == 2'h0; // see [R04]
	assign ctrl_write = wr_en && cnt_hit;
	always_comb
	begin
		unique case (trig_sel)
			perf_monitor_pkg::TRIG_WRITE: trig_fire = ctrl_write; // see [R04]
			perf_monitor_pkg::TRIG_BREAKPOINT: trig_fire = bp_hit; // see [R05]
			perf_monitor_pkg::TRIG_TIMEBASE: trig_fire = tb_rise; // see [R06]
			perf_monitor_pkg::TRIG_NEGATIVE: trig_fire = msb_vec[0]; // see [R06]
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tb_prev_reg <= 1'b0;
		else
			tb_prev_reg <= time_base_bits[tb_sel];
	end

	// a control write re-arms the trigger; a firing source in the same cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			triggered_reg <= 1'b0;
		else if (trig_fire || arm_write)
			triggered_reg <= 1'b1;
		else if (ctrl_a_wr)
			triggered_reg <= 1'b0;
	end

	assign neg_any = |msb_vec && exc_en; // see [R25]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			exception_reg <= 1'b0;
		else if (neg_any)
			exception_reg <= 1'b1;
		else if (wr_en && paddr == `OFS_STATUS && pwdata[`ST_EXC_BIT])
			exception_reg <= 1'b0;
	end

	assign count_en = triggered_reg && state_ok && !(freeze_on_exc && exception_reg);
	assign monitor_exception = exception_reg;
	assign count_active = count_en;

	// ****************************************
	// sampling and thresholder
	// ****************************************
	logic thr_exceed;
	logic [ADDR_W-1:0] sia_val, sda_val;

	sample_unit #(
		.ADDR_W(ADDR_W)
	) u_sample (
		.pclk(pclk),
		.presetn(presetn),
		.freeze(exception_reg), // see [R13]
		.trace_mode(trace_mode),
		.threshold(threshold),
		.dispatch_valid(dispatch_valid),
		.dispatch_addr(dispatch_addr),
		.lsu_valid(lsu_valid),
		.lsu_sampled(lsu_sampled),
		.lsu_store(lsu_store),
		.lsu_cacheable(lsu_cacheable),
		.lsu_ea(lsu_ea),
		.access_done(access_done),
		.sample_tag(sample_tag),
		.sample_instr_addr(sia_val),
		.sample_data_addr(sda_val),
		.coupled_reg(save_restore_status_coupled),
		.thr_exceed_reg(thr_exceed)
	);

	// ****************************************
	// counters
	// ****************************************
	logic [EVT_W+1:0] evt_vec;
	logic [CNT_W-1:0] cnt_val [N_CNT];

	// top two codes select the sampled miss and threshold events
	assign evt_vec = {thr_exceed, l2_miss_sampled, event_in}; // see [R12] [R15]

	genvar gi;
	generate
		for (gi = 0; gi < N_CNT; gi++)
		begin : g_cnt
			logic [`EVT_SEL_W-1:0] sel;
			logic evt, sh_in;
			assign sel = monitor_control_b[gi*`EVT_SEL_W +: `EVT_SEL_W];
			assign evt = evt_vec[sel]; // see [R23]
			// odd counter of a linked pair takes the older bits of its partner
			if (gi % 2 == 1)
			begin : g_link
				assign sh_in = link ? cnt_val[gi-1][CNT_W-1] : evt; // see [R18]
			end
			else
			begin : g_solo
				assign sh_in = evt;
			end
			assign msb_vec[gi] = cnt_val[gi][CNT_W-1];
			event_counter_cell #(
				.CNT_W(CNT_W)
			) u_cell (
				.pclk(pclk),
				.presetn(presetn),
				.load(wr_en && cnt_hit && cnt_idx == 3'(gi)),
				.load_val(pwdata[CNT_W-1:0]),
				.count_en(count_en), // see [R26]
				.history(history),
				.event_bit(evt),
				.shift_in(sh_in),
				.value_reg(cnt_val[gi])
			);
		end
	endgenerate

	// ****************************************
	// trace mode
	// ****************************************
	logic busy_reg;
	logic [3:0] trace_reg;

	// one instruction in flight; next issue waits for its completion
	assign issue_allow = !trace_mode || !busy_reg || complete_valid; // see [R20]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy_reg <= 1'b0;
		else if (dispatch_valid && trace_mode)
			busy_reg <= 1'b1;
		else if (complete_valid)
			busy_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trace_reg <= 4'h0;
		else if (trace_mode && complete_valid)
			trace_reg <= {complete_map_change, complete_len_access,
				complete_store, complete_load}; // see [R21]
	end
	assign save_restore_status_trace = trace_reg;

	// ****************************************
	// read data
	// ****************************************
	logic [31:0] rd_val;
	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (cnt_hit)
			rd_val = cnt_val[cnt_idx];
		else if (paddr == `OFS_CTRL_A)
			rd_val = monitor_control_a;
		else if (paddr == `OFS_CTRL_B)
			rd_val = monitor_control_b;
		else if (paddr == `OFS_SAMPLE_INSTR)
			rd_val = sia_val;
		else if (paddr == `OFS_SAMPLE_DATA)
			rd_val = sda_val;
		else if (paddr == `OFS_STATUS)
		begin
			rd_val[`ST_EXC_BIT] = exception_reg;
			rd_val[`ST_TRIG_BIT] = triggered_reg;
			rd_val[`ST_COUNT_BIT] = count_en;
			rd_val[`ST_COUPLED_BIT] = save_restore_status_coupled;
			rd_val[`ST_TRACE_LSB +: 4] = trace_reg;
		end
	end

	// captured in the setup phase so the access phase returns flopped data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
			prdata <= rd_val;
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_off_idle;
		mode == perf_monitor_pkg::MODE_OFF |-> !count_en;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("counting while disabled"); // see [R03]
	property p_state_gate;
		count_en && mode == perf_monitor_pkg::MODE_PROB |-> problem_state_bit;
	endproperty
	a_state_gate: assert property (p_state_gate) else $error("state mismatch count"); // see [R01]
	property p_write_trig;
		wr_en && paddr == `OFS_CTRL_A && pwdata[`CTRL_A_TRIG_LSB +: 2] == 2'h0
			&& pwdata[`CTRL_A_MODE_LSB +: 4] == 4'h1 && !pwdata[`CTRL_A_FREEZE_BIT]
			|=> count_en;
	endproperty
	a_write_trig: assert property (p_write_trig) else $error("write did not start"); // see [R04]
	property p_tb_trig;
		trig_sel == perf_monitor_pkg::TRIG_TIMEBASE && tb_rise |=> triggered_reg;
	endproperty
	a_tb_trig: assert property (p_tb_trig) else $error("time base trigger lost"); // see [R06]
	property p_bp_valid;
		trig_sel == perf_monitor_pkg::TRIG_BREAKPOINT && !triggered_reg && !state_ok && !wr_en
			|=> !triggered_reg;
	endproperty
	a_bp_valid: assert property (p_bp_valid) else $error("bad breakpoint match"); // see [R10]
	property p_neg_exc;
		exc_en && msb_vec[0] |=> exception_reg;
	endproperty
	a_neg_exc: assert property (p_neg_exc) else $error("negative not flagged"); // see [R25]
	property p_trace_serial;
		trace_mode && dispatch_valid ##1 trace_mode && !complete_valid |-> !issue_allow;
	endproperty
	a_trace_serial: assert property (p_trace_serial) else $error("issue while busy"); // see [R20]
	property p_trace_rec;
		trace_mode && complete_valid |=> trace_reg[0] == $past(complete_load)
			&& trace_reg[1] == $past(complete_store);
	endproperty
	a_trace_rec: assert property (p_trace_rec) else $error("trace record wrong"); // see [R21]
	c_count: cover property (!count_en ##1 count_en);
	c_bp_start: cover property (trig_sel == perf_monitor_pkg::TRIG_BREAKPOINT && bp_hit);
	c_history: cover property (history && link && count_en [*4]);
	c_exc: cover property (exception_reg && freeze_on_exc);
endmodule
`default_nettype wire

// ==== testbench/core_model.sv ====
// pipeline stand-in: dispatches when allowed, completes each instruction three cycles later
`default_nettype none
module core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [4:0] n_req,
	input wire logic issue_allow,
	output logic dispatch_valid,
	output logic [31:0] dispatch_addr,
	output logic complete_valid,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// dispatch and completion
	// ****
	logic [4:0] left_reg;
	logic [2:0] flight_reg;
	// greedy on purpose, so that only the gate can hold back issue
	assign dispatch_valid = (left_reg != 5'h00) && issue_allow;
	assign complete_valid = flight_reg[2];
	assign busy = (left_reg != 5'h00) || (flight_reg != 3'h0);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			left_reg <= 5'h00;
			flight_reg <= 3'h0;
			dispatch_addr <= 32'h0000_1000;
		end
		else
		begin
			if (go)
				left_reg <= n_req;
			else if (dispatch_valid)
				left_reg <= left_reg - 5'h01;
			flight_reg <= {flight_reg[1:0], dispatch_valid};
			if (dispatch_valid)
				dispatch_addr <= dispatch_addr + 32'h0000_0004;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/tb_perf_monitor_count_control.sv ====
// self-checking bench for the performance monitor count control
`default_nettype none
module tb_perf_monitor_count_control;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// signals
	// ****
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
	logic problem_state_bit = 1'b0, process_mark_bit = 1'b0, branch_finish_valid = 1'b0;
	logic lsu_valid = 1'b0, lsu_sampled = 1'b0, lsu_store = 1'b0, lsu_cacheable = 1'b0;
	logic access_done = 1'b0, trace_on = 1'b0, l2_miss_sampled = 1'b0, complete_load = 1'b1;
	logic complete_store = 1'b0, complete_len_access = 1'b0, complete_map_change = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, instr_breakpoint_reg = 32'h0, branch_finish_addr = 32'h0;
	logic [31:0] lsu_ea = 32'h0, rd, prdata, dispatch_addr;
	logic [3:0] time_base_bits = 4'h0, save_restore_status_trace;
	logic [13:0] event_in = 14'h0000;
	logic [4:0] n_req = 5'h00;
	logic pready, pslverr, perr, sample_tag, issue_allow, save_restore_status_coupled;
	logic monitor_exception, count_active, dispatch_valid, complete_valid, busy;
	int fail_count = 0, samples_checked = 0, tags = 0, inflight = 0, overlap = 0;
	logic [5:0] thr_t [6] = '{6'h03, 6'h03, 6'h03, 6'h03, 6'h3F, 6'h3F};
	logic [2:0] flg_t [6] = '{3'h5, 3'h5, 3'h7, 3'h6, 3'h5, 3'h5};
	int wait_t [6] = '{8, 1, 8, 8, 70, 40};
	logic [31:0] inc_t [6] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
	perf_monitor_count_control perf_monitor_count_control_inst (.*);
	core_model core_model_inst (.*);
	always #12.5 pclk = ~pclk;
	// in trace mode a dispatch is legal only once nothing else is in flight
	always @(posedge pclk)
	begin
		if (sample_tag === 1'b1)
			tags++;
		if (dispatch_valid && trace_on && inflight > int'(complete_valid))
			overlap++;
		inflight += int'(dispatch_valid) - int'(complete_valid);
	end
	// ****
	// tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic pulse_lsu(input logic [2:0] f, input logic [31:0] ea);
		@(posedge pclk);
		lsu_valid <= 1'b1;
		{lsu_sampled, lsu_store, lsu_cacheable} <= f;
		lsu_ea <= ea;
		@(posedge pclk);
		lsu_valid <= 1'b0;
		@(negedge pclk);
	endtask
	task automatic branch(input logic [31:0] a);
		@(posedge pclk);
		branch_finish_valid <= 1'b1;
		branch_finish_addr <= a;
		@(posedge pclk);
		branch_finish_valid <= 1'b0;
		@(negedge pclk);
	endtask
	task automatic run(input logic [4:0] n);
		@(posedge pclk);
		n_req <= n;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		while (busy === 1'b1)
			@(posedge pclk);
	endtask
	// counting is gated by the problem state, so exactly n bits enter
	task automatic shift_in(input int n, input logic [31:0] pat);
		for (int i = n - 1; i >= 0; i--)
		begin
			problem_state_bit <= 1'b1;
			event_in <= {13'h0000, pat[i]};
			@(posedge pclk);
		end
		problem_state_bit <= 1'b0;
		event_in <= 14'h0000;
	endtask
	function automatic logic exp_state(input int m, input logic pr, input logic mk);
		case (m)
			2: return !pr;
			3: return pr;
			4: return mk & pr;
			5: return !mk & pr;
			6: return mk & !pr;
			7: return !mk & !pr;
			8: return mk;
			default: return !mk;
		endcase
	endfunction
	task automatic close_out;
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ****
	// tests
	// ****
	initial
	begin
		cyc(20000);
		fail_count++;
		close_out();
	end
	initial
	begin
		cyc(6);
		presetn <= 1'b1;
		rdc(8'h00, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk(32'(perr), 32'h1);
		chk(rd, 32'h0);
		wr(8'h04, 32'h3000_0000);
		wr(8'h00, 32'h0000_0001);
		event_in <= 14'h0008;
		cyc(5);
		event_in <= 14'h0000;
		rdc(8'h3C, 32'h5);
		wr(8'h00, 32'h0);
		event_in <= 14'h0008;
		cyc(5);
		event_in <= 14'h0000;
		rdc(8'h3C, 32'h5);
		for (int m = 2; m < 10; m++)
			for (int s = 0; s < 4; s++)
			begin
				problem_state_bit <= s[0];
				process_mark_bit <= s[1];
				wr(8'h00, 32'(m));
				@(negedge pclk);
				chk(32'(count_active), 32'(exp_state(m, s[0], s[1])));
				@(posedge pclk);
			end
		problem_state_bit <= 1'b0;
		instr_breakpoint_reg <= 32'h0000_2000;
		wr(8'h00, 32'h0000_0013);
		branch(32'h0000_2000);
		chk(32'(count_active), 32'h0);
		@(posedge pclk);
		problem_state_bit <= 1'b1;
		branch(32'h0000_2004);
		chk(32'(count_active), 32'h0);
		branch(32'h0000_2000);
		chk(32'(count_active), 32'h1);
		wr(8'h00, 32'h0000_00A1);
		time_base_bits <= 4'h1;
		cyc(2);
		@(negedge pclk);
		chk(32'(count_active), 32'h0);
		@(posedge pclk);
		time_base_bits <= 4'h5;
		cyc(2);
		@(negedge pclk);
		chk(32'(count_active), 32'h1);
		run(5'h10);
		chk(32'(tags), 32'h1);
		rdc(8'h10, 32'h0000_103C);
		pulse_lsu(3'h5, 32'h0000_4440);
		chk(32'(save_restore_status_coupled), 32'h1);
		rdc(8'h14, 32'h0000_4440);
		run(5'h10);
		@(negedge pclk);
		chk(32'(save_restore_status_coupled), 32'h0);
		rdc(8'h10, 32'h0000_107C);
		wr(8'h00, 32'h0000_1031);
		@(negedge pclk);
		chk(32'(count_active), 32'h0);
		wr(8'h20, 32'h8000_0000);
		cyc(2);
		@(negedge pclk);
		chk(32'(count_active), 32'h1);
		chk(32'(monitor_exception), 32'h1);
		run(5'h10);
		rdc(8'h10, 32'h0000_107C);
		pulse_lsu(3'h5, 32'h0000_7770);
		rdc(8'h14, 32'h0000_4440);
		wr(8'h20, 32'h0);
		wr(8'h08, 32'h1);
		wr(8'h04, 32'h0000_000E);
		l2_miss_sampled <= 1'b1;
		cyc(3);
		l2_miss_sampled <= 1'b0;
		rdc(8'h20, 32'h3);
		wr(8'h04, 32'h0000_000F);
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h00, {10'h000, thr_t[i], 16'h0001});
			wr(8'h20, 32'h0);
			pulse_lsu(flg_t[i], 32'h0000_6000);
			cyc(wait_t[i]);
			access_done <= 1'b1;
			cyc(1);
			access_done <= 1'b0;
			cyc(2);
			rdc(8'h20, inc_t[i]);
		end
		problem_state_bit <= 1'b0;
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h0000_0603);
		wr(8'h20, 32'h0);
		shift_in(32, 32'h8000_0005);
		rdc(8'h20, 32'h8000_0005);
		shift_in(1, 32'h0);
		rdc(8'h20, 32'h0000_000A);
		rdc(8'h24, 32'h0000_0001);
		wr(8'h00, 32'h0000_0801);
		trace_on <= 1'b1;
		{complete_load, complete_store, complete_len_access} <= 3'h3;
		run(5'h03);
		chk(32'(overlap), 32'h0);
		chk({28'h0000000, save_restore_status_trace}, 32'h6);
		pulse_lsu(3'h1, 32'h0000_5550);
		rdc(8'h14, 32'h0000_5550);
		rdc(8'h08, 32'h0000_006E);
		close_out();
	end
endmodule
`default_nettype wire
